// ===== core/etdiv_top.sv
// Operation
// - Divide the selected reference by the divisor to make a 35 us timebase.
// - Reference is oscillator clock or bus clock, picked by a config bit.
// - Reset copies nonvolatile divisor and lock bit into volatile registers.
// - Lock disable bit: one means lock off, zero means lock on.
// - While locked, writes to both volatile divisor registers are ignored.
// - While locked, erase and program of nonvolatile divisor bytes are blocked.
// - Divisor bits always readable; writable only with latch clear and lock off.
// - With lock off, nonvolatile bytes erase and program like EEPROM bytes.
// - Nonvolatile changes reach volatile registers only at the next reset.
// - A zero nonvolatile lock bit locks permanently after the next reset.
`timescale 1ns/1ps
`default_nettype none
`include "etdiv_params.svh"

module etdiv_top
  import etdiv_pkg::*;
#(
  parameter int DIV_W = `ETDIV_DIV_W,
  parameter int TICKS_W = `ETDIV_TICKS_W
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic nv_power_on,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata_ff,
  output logic hreadyout_ff,
  output logic hresp_ff,
  // Reference clock and EEPROM unit
  input wire logic oscillator_clock,
  input wire logic eeprom_latch_bit,
  output logic timebase_tick,
  output logic lock_active_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator synchroniser and reference select

  logic osc_meta_ff;
  logic osc_sync_ff;
  logic osc_prev_ff;
  logic nxt_osc_meta;
  logic nxt_osc_sync;
  logic nxt_osc_prev;
  logic clk_sel_ff;
  logic ref_tick;

  // Two flops before the pin is read, a third only for the edge
  always_comb begin
    nxt_osc_meta = oscillator_clock;
    nxt_osc_sync = osc_meta_ff;
    nxt_osc_prev = osc_sync_ff;
  end

  always_ff @(posedge clk) begin
    osc_meta_ff <= nxt_osc_meta;
    osc_sync_ff <= nxt_osc_sync;
    osc_prev_ff <= nxt_osc_prev;
  end

  always_comb begin
    // Bus clock gives a pulse every cycle, oscillator one per rising edge
    ref_tick = clk_sel_ff ? 1'b1 : (osc_sync_ff & ~osc_prev_ff);
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite front end

  etdiv_dphase_t dp_ff;
  etdiv_dphase_t nxt_dp;
  logic rd_wait_ff;
  logic nxt_rd_wait;
  logic nxt_hreadyout;
  logic nxt_hresp;
  logic [31:0] nxt_hrdata;
  logic accept;
  logic wr_now;
  logic [7:0] wr_byte;

  always_comb begin
    accept = hsel & htrans[1] & hready;
    wr_now = dp_ff.valid & dp_ff.write;
    wr_byte = hwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  etdiv_divisor_t vol_ff;
  etdiv_divisor_t nxt_vol;
  logic [7:0] nv_high_ff;
  logic [7:0] nxt_nv_high;
  logic [7:0] nv_low_ff;
  logic [7:0] nxt_nv_low;
  logic nxt_clk_sel;
  logic refused_ff;
  logic nxt_refused;
  logic [TICKS_W-1:0] ticks_ff;
  logic [TICKS_W-1:0] nxt_ticks;
  logic nxt_lock_active;
  logic vol_writable;
  logic nv_writable;
  logic refuse_evt;

  always_comb begin
    vol_writable = ~eeprom_latch_bit & vol_ff.secd;
    nv_writable = vol_ff.secd;
  end

  // Volatile divisor and lock bit
  always_comb begin
    nxt_vol = vol_ff;
    if (rst) begin
      nxt_vol.secd = nv_high_ff[`ETDIV_HIGH_SECD_BIT];
      nxt_vol.div = {nv_high_ff[`ETDIV_HIGH_DIV_MSB:0], nv_low_ff};
    end else if (wr_now && vol_writable) begin
      if (dp_ff.addr == `ETDIV_ADDR_DIV_HIGH) begin
        nxt_vol.secd = wr_byte[`ETDIV_HIGH_SECD_BIT];
        nxt_vol.div[DIV_W-1:8] = wr_byte[`ETDIV_HIGH_DIV_MSB:0];
      end else if (dp_ff.addr == `ETDIV_ADDR_DIV_LOW) begin
        nxt_vol.div[7:0] = wr_byte;
      end
    end
  end

  // Nonvolatile bytes: only power-on, erase and program change them
  always_comb begin
    nxt_nv_high = nv_high_ff;
    nxt_nv_low = nv_low_ff;
    if (nv_power_on) begin
      nxt_nv_high = `ETDIV_NV_ERASED;
      nxt_nv_low = `ETDIV_NV_ERASED;
    end else if (!rst && wr_now && nv_writable) begin
      if (dp_ff.addr == `ETDIV_ADDR_NV_HIGH) begin
        nxt_nv_high = nv_high_ff & wr_byte;
      end else if (dp_ff.addr == `ETDIV_ADDR_NV_LOW) begin
        nxt_nv_low = nv_low_ff & wr_byte;
      end else if (dp_ff.addr == `ETDIV_ADDR_NV_ERASE) begin
        if (wr_byte[`ETDIV_ERASE_HIGH_BIT]) begin
          nxt_nv_high = `ETDIV_NV_ERASED;
        end
        if (wr_byte[`ETDIV_ERASE_LOW_BIT]) begin
          nxt_nv_low = `ETDIV_NV_ERASED;
        end
      end
    end
  end

  // Refused-write detection
  always_comb begin
    refuse_evt = 1'b0;
    if (wr_now) begin
      // Only writes that the lock or the latch drops are flagged
      case (dp_ff.addr)
        `ETDIV_ADDR_DIV_HIGH, `ETDIV_ADDR_DIV_LOW: begin
          refuse_evt = ~vol_writable;
        end
        `ETDIV_ADDR_NV_HIGH, `ETDIV_ADDR_NV_LOW, `ETDIV_ADDR_NV_ERASE: begin
          refuse_evt = ~nv_writable;
        end
        default: begin
          refuse_evt = 1'b0;
        end
      endcase
    end
  end

  // Config, status and tick counter
  always_comb begin
    nxt_clk_sel = clk_sel_ff;
    nxt_refused = refused_ff;
    nxt_ticks = ticks_ff;
    nxt_lock_active = ~vol_ff.secd;
    if (rst) begin
      nxt_clk_sel = `ETDIV_CLKSEL_RESET;
      nxt_refused = 1'b0;
      nxt_ticks = '0;
      nxt_lock_active = 1'b0;
    end else begin
      if (wr_now && dp_ff.addr == `ETDIV_ADDR_CONFIG) begin
        nxt_clk_sel = wr_byte[`ETDIV_CFG_CLKSEL_BIT];
      end
      if (wr_now && dp_ff.addr == `ETDIV_ADDR_STATUS &&
          wr_byte[`ETDIV_STAT_REFUSED_BIT]) begin
        nxt_refused = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (refuse_evt) begin
        nxt_refused = 1'b1;
      end
      // Tick count wraps without notice
      if (timebase_tick) begin
        nxt_ticks = ticks_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    vol_ff <= nxt_vol;
    nv_high_ff <= nxt_nv_high;
    nv_low_ff <= nxt_nv_low;
    clk_sel_ff <= nxt_clk_sel;
    refused_ff <= nxt_refused;
    ticks_ff <= nxt_ticks;
    lock_active_ff <= nxt_lock_active;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencing: writes zero wait, reads one wait state

  function automatic logic [31:0] read_mux(input logic [7:0] addr);
    logic [31:0] d;
    d = '0;
    case (addr)
      `ETDIV_ADDR_DIV_HIGH: begin
        d[`ETDIV_HIGH_SECD_BIT] = vol_ff.secd;
        d[`ETDIV_HIGH_DIV_MSB:0] = vol_ff.div[DIV_W-1:8];
      end
      `ETDIV_ADDR_DIV_LOW: begin
        d[7:0] = vol_ff.div[7:0];
      end
      `ETDIV_ADDR_NV_HIGH: begin
        d[7:0] = nv_high_ff;
      end
      `ETDIV_ADDR_NV_LOW: begin
        d[7:0] = nv_low_ff;
      end
      `ETDIV_ADDR_CONFIG: begin
        d[`ETDIV_CFG_CLKSEL_BIT] = clk_sel_ff;
      end
      `ETDIV_ADDR_STATUS: begin
        d[`ETDIV_STAT_REFUSED_BIT] = refused_ff;
        d[`ETDIV_STAT_LOCKED_BIT] = ~vol_ff.secd;
        d[`ETDIV_STAT_LATCH_BIT] = eeprom_latch_bit;
      end
      `ETDIV_ADDR_TICKS: begin
        d[TICKS_W-1:0] = ticks_ff;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  always_comb begin
    nxt_dp = dp_ff;
    nxt_rd_wait = 1'b0;
    nxt_hreadyout = 1'b1;
    // Every transfer answers OKAY
    nxt_hresp = 1'b0;
    nxt_hrdata = hrdata_ff;
    if (rst) begin
      nxt_dp = '0;
      nxt_hrdata = '0;
    end else if (rd_wait_ff) begin
      // Sample after any preceding write has landed
      nxt_hrdata = read_mux(dp_ff.addr);
      nxt_dp.valid = 1'b0;
    end else begin
      nxt_dp.valid = accept;
      nxt_dp.write = hwrite;
      nxt_dp.addr = haddr[`ETDIV_ADDR_W-1:0];
      if (accept && !hwrite) begin
        nxt_rd_wait = 1'b1;
        nxt_hreadyout = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    dp_ff <= nxt_dp;
    rd_wait_ff <= nxt_rd_wait;
    hreadyout_ff <= nxt_hreadyout;
    hrdata_ff <= nxt_hrdata;
    hresp_ff <= nxt_hresp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider

  etdiv_counter #(
    .DIV_W(DIV_W)
  ) u_etdiv_counter (
    .clk(clk),
    .rst(rst),
    .ref_tick(ref_tick),
    .divisor(vol_ff.div),
    .tick_ff(timebase_tick)
  );

endmodule
`default_nettype wire

// ===== core/etdiv_params.svh
`ifndef ETDIV_PARAMS_SVH
`define ETDIV_PARAMS_SVH

// Register byte addresses
`define ETDIV_ADDR_DIV_HIGH 8'h00
`define ETDIV_ADDR_DIV_LOW 8'h04
`define ETDIV_ADDR_NV_HIGH 8'h08
`define ETDIV_ADDR_NV_LOW 8'h0C
`define ETDIV_ADDR_CONFIG 8'h10
`define ETDIV_ADDR_NV_ERASE 8'h14
`define ETDIV_ADDR_STATUS 8'h18
`define ETDIV_ADDR_TICKS 8'h1C
`define ETDIV_ADDR_W 8

// High byte layout: lock disable on top, divisor bits 10..8 at the bottom
`define ETDIV_HIGH_SECD_BIT 7
`define ETDIV_HIGH_DIV_MSB 2
`define ETDIV_DIV_W 11
`define ETDIV_DIV_HI_W 3

// Config, erase command and status bits
`define ETDIV_CFG_CLKSEL_BIT 0
`define ETDIV_ERASE_HIGH_BIT 0
`define ETDIV_ERASE_LOW_BIT 1
`define ETDIV_STAT_REFUSED_BIT 0
`define ETDIV_STAT_LOCKED_BIT 1
`define ETDIV_STAT_LATCH_BIT 2

// Values
`define ETDIV_NV_ERASED 8'hFF
`define ETDIV_CLKSEL_RESET 1'b0
`define ETDIV_TICKS_W 16
`define ETDIV_TIMEBASE_NS 35000

`endif

// ===== core/etdiv_pkg.sv
package etdiv_pkg;

  // Volatile or nonvolatile divisor image
  typedef struct packed {
    logic secd;
    logic [10:0] div;
  } etdiv_divisor_t;

  // Data-phase bookkeeping of one AHB transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } etdiv_dphase_t;

endpackage

// ===== core/etdiv_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "etdiv_params.svh"

module etdiv_counter #(
  parameter int DIV_W = `ETDIV_DIV_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Reference pulses and divisor
  input wire logic ref_tick,
  input wire logic [DIV_W-1:0] divisor,
  // Timebase
  output logic tick_ff
);

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;
  logic nxt_tick;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (rst) begin
      nxt_cnt = '0;
    end else if (divisor == '0) begin
      // Zero divisor holds the divider idle
      nxt_cnt = '0;
    end else if (ref_tick) begin
      if (cnt_ff + 1'b1 >= divisor) begin
        nxt_cnt = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    cnt_ff <= nxt_cnt;
    tick_ff <= nxt_tick;
  end

endmodule
`default_nettype wire

// ===== dv/etdiv_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module etdiv_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata_ff,
  input wire logic hreadyout_ff,
  input wire logic hresp_ff,
  // Timebase and lock
  input wire logic timebase_tick,
  input wire logic lock_active_ff
);
  wire logic acc = hsel && htrans[1] && hready;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  read_wait_a: assert property (acc && !hwrite |=> !hreadyout_ff ##1 hreadyout_ff)
    else $error("read answer timing");
  write_fast_a: assert property (acc && hwrite |=> hreadyout_ff)
    else $error("write wait state");
  one_wait_a: assert property (!hreadyout_ff |=> hreadyout_ff)
    else $error("wait state too long");
  resp_okay_a: assert property (!hresp_ff)
    else $error("error response");
  data_hold_a: assert property (hreadyout_ff && $past(hreadyout_ff) |-> $stable(hrdata_ff))
    else $error("read data moved");
  upper_zero_a: assert property (hrdata_ff[31:16] == 16'h0)
    else $error("upper read bits set");
  lock_stays_a: assert property (lock_active_ff |=> lock_active_ff)
    else $error("lock dropped");
  reset_load_a: assert property (disable iff (1'b0) rst |=> !lock_active_ff && !timebase_tick)
    else $error("reset state wrong");
  cover property (acc && !hwrite);
  cover property ($rose(lock_active_ff));
  cover property (timebase_tick);
endmodule
bind etdiv_top etdiv_assertions u_etdiv_assertions (
  .clk(clk),
  .rst(rst),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hrdata_ff(hrdata_ff),
  .hreadyout_ff(hreadyout_ff),
  .hresp_ff(hresp_ff),
  .timebase_tick(timebase_tick),
  .lock_active_ff(lock_active_ff)
);
`default_nettype wire

// ===== dv/etdiv_tb.sv
`timescale 1ns/1ps
`default_nettype none
module etdiv_tb;
  logic clk, rst, nv_power_on, hsel, hwrite, oscillator_clock, eeprom_latch_bit;
  logic [31:0] haddr, hwdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic [31:0] hrdata_ff;
  wire logic hreadyout_ff, hresp_ff, timebase_tick, lock_active_ff;
  int error_cnt, n_tests, vh, vl, cfg, rf, d, tk;
  int nh = 'hFF;
  int nl = 'hFF;
  int osc_n = 0;
  int ra[8] = '{0, 4, 8, 'hC, 'h10, 'h18, 'h1C, 'h20};
  etdiv_top u_etdiv_top (.clk(clk), .rst(rst), .nv_power_on(nv_power_on), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout_ff), .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff),
    .hresp_ff(hresp_ff), .oscillator_clock(oscillator_clock),
    .eeprom_latch_bit(eeprom_latch_bit), .timebase_tick(timebase_tick),
    .lock_active_ff(lock_active_ff));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Free-running reference, eight bus cycles a period
  always @(posedge clk) begin
    osc_n <= (osc_n == 3) ? 0 : osc_n + 1;
    if (osc_n == 3) oscillator_clock <= ~oscillator_clock;
  end
  // Model of the tick count register
  always @(negedge clk) begin
    if (rst) tk <= 0;
    else if (timebase_tick === 1'b1) tk <= tk + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mrd(input int a);
    case (a)
      0: return vh;
      4: return vl;
      8: return nh;
      'hC: return nl;
      'h10: return cfg;
      'h18: return {29'h0, eeprom_latch_bit, !vh[7], rf[0]};
      'h1C: return tk;
      default: return 32'h0;
    endcase
  endfunction
  task automatic mwr(input int a, input int x);
    case (a)
      0, 4: if (eeprom_latch_bit || !vh[7]) rf = 1;
        else if (a == 0) vh = x & 'h87;
        else vl = x & 'hFF;
      8: if (!vh[7]) rf = 1; else nh &= x;
      'hC: if (!vh[7]) rf = 1; else nl &= x;
      'h10: cfg = x & 1;
      'h14: if (!vh[7]) rf = 1;
        else begin
          if (x[0]) nh = 'hFF;
          if (x[1]) nl = 'hFF;
        end
      'h18: if (x[0]) rf = 0;
      default: ;
    endcase
  endtask
  // Answer is taken where hready is seen high, then the edge is passed
  task wt;
    do @(negedge clk); while (hreadyout_ff !== 1'b1);
    r = hrdata_ff;
    @(posedge clk);
  endtask
  task automatic bus(input logic w, input int a, input int x);
    hsel <= 1'b1;
    haddr <= {24'h0, a[7:0]};
    htrans <= 2'b10;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= x;
    wt();
  endtask
  task automatic wr(input int a, input int x);
    bus(1'b1, a, x);
    mwr(a, x);
  endtask
  task automatic rd(input int a);
    bus(1'b0, a, 0);
    chk(r, mrd(a));
  endtask
  task automatic sdiv(input int v);
    wr(0, 'h80 | (v >> 8));
    wr(4, v & 'hFF);
  endtask
  task automatic rstp;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    vh = nh & 'h87;
    vl = nl;
    cfg = 0;
    rf = 0;
    @(posedge clk);
  endtask
  task automatic meas(input int exp);
    int n;
    n = 0;
    do @(negedge clk); while (timebase_tick !== 1'b1);
    do begin
      @(negedge clk);
      n++;
    end while (timebase_tick !== 1'b1);
    chk(n, exp);
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #240000;
    error_cnt++;
    stop_test();
  end
  initial begin
    {rst, nv_power_on, hsel, hwrite, oscillator_clock, eeprom_latch_bit} = 6'b110000;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    void'($urandom(32'h161fc1ca));
    fork
      rstp();
      begin
        repeat (2) @(posedge clk);
        nv_power_on <= 1'b0;
      end
    join
    foreach (ra[i]) rd(ra[i]);
    d = $urandom_range(2047, 2);
    sdiv(d);
    rd(0);
    rd(4);
    eeprom_latch_bit <= 1'b1;
    wr(4, ~d);
    rd(4);
    rd('h18);
    eeprom_latch_bit <= 1'b0;
    wr('h18, 1);
    rd('h18);
    d = $urandom_range(20, 2);
    wr('h10, 1);
    sdiv(d);
    meas(d);
    wr('h10, 0);
    d = int'($floor(250.0e6 / 8.0 * 35.0e-6 + 0.5));
    sdiv(d);
    meas(d * 8);
    rd('h1C);
    wr('h14, 3);
    wr(8, 'h01);
    wr('hC, 'h12);
    rd(8);
    rd('hC);
    rd(0);
    rstp();
    rd(0);
    rd(4);
    chk(lock_active_ff, 1'b1);
    wr(4, 'h55);
    rd(4);
    rd('h18);
    wr('h14, 3);
    rd(8);
    rstp();
    rd(0);
    chk(lock_active_ff, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
